// [rtl/register_preload_observe_test.sv]
// top of the preload, observe, power-up clear and lock test-access block
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module register_preload_observe_test (
    input  wire logic                                  pclk,
    input  wire logic                                  presetn,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [preload_observe_pkg::ADDR_WIDTH-1:0] paddr,
    input  wire logic [preload_observe_pkg::DATA_WIDTH-1:0] pwdata,
    output var  logic [preload_observe_pkg::DATA_WIDTH-1:0] prdata,
    output var  logic                                  pready,
    output var  logic                                  pslverr,
    input  wire logic                                  preload_enable,
    input  wire logic                                  observe_enable,
    input  wire logic                                  preload_clock,
    input  wire logic                                  flop_choice,
    input  wire logic                                  bank_parity,
    input  wire logic [23:0]                           io_pin_in,
    input  wire preload_observe_pkg::macro_terms_type  terms,
    input  wire logic [23:0]                           comb_term,
    input  wire logic [23:0]                           oe_term,
    output var  logic [23:0]                           out_pin,
    output var  logic [23:0]                           out_pin_oe
);
    import preload_observe_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    logic                       lock;
    logic                       next_lock;
    logic [CLEAR_CNT_WIDTH-1:0] clear_cnt;
    logic [CLEAR_CNT_WIDTH-1:0] next_clear_cnt;
    logic                       clear_busy;
    logic                       next_clear_busy;
    logic                       preload_clock_prev;
    logic [PATTERN_AW-1:0]      pattern_addr;
    logic [PATTERN_AW-1:0]      next_pattern_addr;
    logic [23:0]                comb_config;
    logic [23:0]                next_comb_config;
    logic [23:0]                polarity;
    logic [23:0]                next_polarity;
    logic [DATA_WIDTH-1:0]      next_prdata;
    logic                       next_pready;
    logic                       next_pslverr;
    logic [23:0]                next_out_pin;
    logic [23:0]                next_out_pin_oe;

    logic                       preload_active;
    logic                       observe_active;
    logic                       access;
    logic                       commit;
    logic                       mem_wr;
    logic                       mem_rd;
    logic [DATA_WIDTH-1:0]      mem_rdata;
    logic [DATA_WIDTH-1:0]      read_word;
    logic [DATA_WIDTH-1:0]      pattern_word;
    logic [23:0]                first_q;
    logic [23:0]                second_q;
    logic [23:0]                buried_first;
    logic [11:0]                odd_pins;
    preload_req_type            preload_req;

    function automatic logic addr_mapped(input logic [ADDR_WIDTH-1:0] a);
        addr_mapped = (a == STATUS_ADDR)       || (a == LOCK_ADDR)
                   || (a == PATTERN_ADDR_ADDR) || (a == PATTERN_DATA_ADDR)
                   || (a == FIRST_STATE_ADDR)  || (a == SECOND_STATE_ADDR)
                   || (a == COMB_CONFIG_ADDR)  || (a == POLARITY_ADDR)
                   || (a == BURIED_MASK_ADDR);
    endfunction

    function automatic logic write_hit(input logic [ADDR_WIDTH-1:0] a,
                                       input logic [ADDR_WIDTH-1:0] target,
                                       input logic                  go,
                                       input logic                  wr);
        write_hit = go && wr && (a == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // mode entry

    always_comb begin
        // mode enables are digital stand-ins for the high-voltage levels
        preload_active = preload_enable && !lock && !clear_busy;
        observe_active = observe_enable && !lock && !clear_busy;
        for (int k = 0; k < GROUP_SIZE; k++) begin
            odd_pins[k] = io_pin_in[2*k+1];
        end
        preload_req.strobe      = preload_active && preload_clock
                                  && !preload_clock_prev;
        preload_req.flop_choice = flop_choice;
        preload_req.bank_parity = bank_parity;
        preload_req.data        = odd_pins;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preload_clock_prev <= 1'b0;
        end else begin
            preload_clock_prev <= preload_clock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power-up clear

    always_comb begin
        next_clear_cnt  = clear_cnt;
        next_clear_busy = clear_busy;
        if (clear_busy) begin
            if (clear_cnt == CLEAR_CNT_LAST) begin
                next_clear_busy = 1'b0;
            end else begin
                next_clear_cnt = clear_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_cnt  <= '0;
            clear_busy <= 1'b1;
        end else begin
            clear_cnt  <= next_clear_cnt;
            clear_busy <= next_clear_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // security lock

    always_comb begin
        // set only: a lock is undone solely by a full reset (erase)
        next_lock = lock
                    || (write_hit(paddr, LOCK_ADDR, commit, pwrite)
                        && pwdata[LOCK_SET_BIT]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock <= 1'b0;
        end else begin
            lock <= next_lock;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flop bank and pattern store

    macrocell_flop_bank u_flop_bank (
        .pclk                  (pclk),
        .presetn               (presetn),
        .clear                 (clear_busy),
        .hold                  (preload_active),
        .terms                 (terms),
        .preload               (preload_req),
        .first_macrocell_flop  (first_q),
        .second_macrocell_flop (second_q)
    );

    pattern_memory u_pattern_memory (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (mem_wr),
        .rd_en   (mem_rd),
        .addr    (pattern_addr),
        .wdata   (pwdata),
        .rdata   (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb slave

    always_comb begin
        access = psel && penable;
        commit = access && pready;
        mem_wr = write_hit(paddr, PATTERN_DATA_ADDR, commit, pwrite);
        // read issued in setup so the word is ready in the access phase
        mem_rd = psel && !penable && !pwrite
                 && (paddr == PATTERN_DATA_ADDR);
        buried_first = comb_config;
        pattern_word = lock ? PROGRAMMED_WORD : mem_rdata;
    end

    always_comb begin
        read_word    = ZERO_WORD;
        unique case (paddr)
            STATUS_ADDR: begin
                read_word[STATUS_PRELOAD_BIT] = preload_active;
                read_word[STATUS_OBSERVE_BIT] = observe_active;
                read_word[STATUS_LOCK_BIT]    = lock;
                read_word[STATUS_CLEAR_BIT]   = clear_busy;
            end
            LOCK_ADDR:         read_word[LOCK_SET_BIT] = lock;
            PATTERN_ADDR_ADDR: read_word[PATTERN_AW-1:0] = pattern_addr;
            PATTERN_DATA_ADDR: read_word = pattern_word;
            FIRST_STATE_ADDR:  read_word[23:0] = first_q;
            SECOND_STATE_ADDR: read_word[23:0] = second_q;
            COMB_CONFIG_ADDR:  read_word[23:0] = comb_config;
            POLARITY_ADDR:     read_word[23:0] = polarity;
            BURIED_MASK_ADDR:  read_word[23:0] = buried_first;
            default:           read_word = ZERO_WORD;
        endcase
        next_pready  = access && !pready;
        next_pslverr = access && !pready && !addr_mapped(paddr);
        next_prdata  = prdata;
        if (access && !pready && !pwrite) begin
            next_prdata = read_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= ZERO_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_comb begin
        // polarity only shapes the pins, never the stored flops
        next_pattern_addr = pattern_addr;
        if (write_hit(paddr, PATTERN_ADDR_ADDR, commit, pwrite)) begin
            next_pattern_addr = pwdata[PATTERN_AW-1:0];
        end
        next_comb_config = comb_config;
        if (write_hit(paddr, COMB_CONFIG_ADDR, commit, pwrite)) begin
            next_comb_config = pwdata[23:0];
        end
        next_polarity = polarity;
        if (write_hit(paddr, POLARITY_ADDR, commit, pwrite)) begin
            next_polarity = pwdata[23:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern_addr <= '0;
            comb_config  <= COMB_CONFIG_RESET;
            polarity     <= POLARITY_RESET;
        end else begin
            pattern_addr <= next_pattern_addr;
            comb_config  <= next_comb_config;
            polarity     <= next_polarity;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pins

    always_comb begin
        for (int i = 0; i < MACRO_COUNT; i++) begin
            if (observe_active) begin
                next_out_pin[i] = second_q[i];
            end else if (comb_config[i]) begin
                next_out_pin[i] = comb_term[i] ^ polarity[i];
            end else begin
                next_out_pin[i] = first_q[i] ^ polarity[i];
            end
        end
        // pin enables follow their enable terms one cycle later, through a register
        next_out_pin_oe = oe_term;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_pin    <= 24'h000000;
            out_pin_oe <= 24'h000000;
        end else begin
            out_pin    <= next_out_pin;
            out_pin_oe <= next_out_pin_oe;
        end
    end
endmodule
`default_nettype wire

// [rtl/preload_observe_pkg.sv]
// shared constants, register map and carrier types of the test-access block
package preload_observe_pkg;

    localparam int MACRO_COUNT   = 24;
    localparam int GROUP_SIZE    = 12;
    localparam int ADDR_WIDTH    = 8;
    localparam int DATA_WIDTH    = 32;
    localparam int PATTERN_DEPTH = 64;
    localparam int PATTERN_AW    = 6;

    // register byte offsets
    localparam logic [7:0] STATUS_ADDR       = 8'h00;
    localparam logic [7:0] LOCK_ADDR         = 8'h04;
    localparam logic [7:0] PATTERN_ADDR_ADDR = 8'h08;
    localparam logic [7:0] PATTERN_DATA_ADDR = 8'h0c;
    localparam logic [7:0] FIRST_STATE_ADDR  = 8'h10;
    localparam logic [7:0] SECOND_STATE_ADDR = 8'h14;
    localparam logic [7:0] COMB_CONFIG_ADDR  = 8'h18;
    localparam logic [7:0] POLARITY_ADDR     = 8'h1c;
    localparam logic [7:0] BURIED_MASK_ADDR  = 8'h20;

    // status and lock field positions
    localparam int STATUS_PRELOAD_BIT = 0;
    localparam int STATUS_OBSERVE_BIT = 1;
    localparam int STATUS_LOCK_BIT    = 2;
    localparam int STATUS_CLEAR_BIT   = 3;
    localparam int LOCK_SET_BIT       = 0;

    // reset values and the word a locked pattern read returns
    localparam logic [23:0] COMB_CONFIG_RESET = 24'h000000;
    localparam logic [23:0] POLARITY_RESET    = 24'h000000;
    localparam logic [31:0] PROGRAMMED_WORD   = 32'hffffffff;
    localparam logic [31:0] ZERO_WORD         = 32'h00000000;

    // power-up clear interval, longest figure rounded down to cycles
    localparam int CLK_PERIOD_NS           = 8;
    localparam int POWERUP_CLEAR_MAX_NS    = 1000;
    localparam int POWERUP_CLEAR_CYCLES    =
        POWERUP_CLEAR_MAX_NS / CLK_PERIOD_NS;
    localparam int CLEAR_CNT_WIDTH         = 8;
    localparam logic [CLEAR_CNT_WIDTH-1:0] CLEAR_CNT_LAST =
        CLEAR_CNT_WIDTH'(POWERUP_CLEAR_CYCLES - 1);

    typedef struct packed {
        logic [23:0] first_d;
        logic [23:0] second_d;
        logic [23:0] first_clk;
        logic [23:0] second_clk;
        logic [23:0] first_rst;
        logic [23:0] second_rst;
    } macro_terms_type;

    typedef struct packed {
        logic        strobe;
        logic        flop_choice;
        logic        bank_parity;
        logic [11:0] data;
    } preload_req_type;

endpackage

// [rtl/pattern_memory.sv]
// configuration pattern store with registered read data
`timescale 1ns/1ns
`default_nettype none
module pattern_memory (
    input  wire logic                                     pclk,
    input  wire logic                                     presetn,
    input  wire logic                                     wr_en,
    input  wire logic                                     rd_en,
    input  wire logic [preload_observe_pkg::PATTERN_AW-1:0] addr,
    input  wire logic [preload_observe_pkg::DATA_WIDTH-1:0] wdata,
    output var  logic [preload_observe_pkg::DATA_WIDTH-1:0] rdata
);
    import preload_observe_pkg::*;

    logic [DATA_WIDTH-1:0] mem [PATTERN_DEPTH];
    logic [DATA_WIDTH-1:0] next_rdata;

    always_comb begin
        next_rdata = rdata;
        if (rd_en) begin
            next_rdata = mem[addr];
        end
    end

    // array carries no reset so it can map onto plain storage
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= ZERO_WORD;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// [rtl/macrocell_flop_bank.sv]
// the 48 macrocell flops with their own clock and reset terms and preload
`timescale 1ns/1ns
`default_nettype none
module macrocell_flop_bank (
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic                                clear,
    input  wire logic                                hold,
    input  wire preload_observe_pkg::macro_terms_type terms,
    input  wire preload_observe_pkg::preload_req_type preload,
    output var  logic [23:0]                         first_macrocell_flop,
    output var  logic [23:0]                         second_macrocell_flop
);
    import preload_observe_pkg::*;

    logic [23:0] first_clk_prev;
    logic [23:0] second_clk_prev;
    logic [23:0] next_first;
    logic [23:0] next_second;

    function automatic logic in_bank(input int idx, input logic parity);
        in_bank = (idx % 2 == 1) == parity;
    endfunction

    always_comb begin
        next_first  = first_macrocell_flop;
        next_second = second_macrocell_flop;
        for (int i = 0; i < MACRO_COUNT; i++) begin
            if (clear) begin
                next_first[i]  = 1'b0;
                next_second[i] = 1'b0;
            end else if (hold) begin
                // normal clocking frozen so only the chosen group moves
                if (preload.strobe && in_bank(i, preload.bank_parity)) begin
                    if (preload.flop_choice) begin
                        next_second[i] = preload.data[i/2];
                    end else begin
                        next_first[i]  = preload.data[i/2];
                    end
                end
            end else begin
                if (terms.first_rst[i]) begin
                    next_first[i] = 1'b0;
                end else if (terms.first_clk[i] && !first_clk_prev[i]) begin
                    next_first[i] = terms.first_d[i];
                end
                if (terms.second_rst[i]) begin
                    next_second[i] = 1'b0;
                end else if (terms.second_clk[i] && !second_clk_prev[i]) begin
                    next_second[i] = terms.second_d[i];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_macrocell_flop  <= 24'h000000;
            second_macrocell_flop <= 24'h000000;
            first_clk_prev        <= 24'h000000;
            second_clk_prev       <= 24'h000000;
        end else begin
            first_macrocell_flop  <= next_first;
            second_macrocell_flop <= next_second;
            first_clk_prev        <= terms.first_clk;
            second_clk_prev       <= terms.second_clk;
        end
    end
endmodule
`default_nettype wire

// [verification/preload_observe_checker.sv]
// assertion checker for the test-access block, bound to its top
`timescale 1ns/1ns
`default_nettype none
module preload_observe_checker (
    input wire logic                                    pclk,
    input wire logic                                    presetn,
    input wire logic                                    psel,
    input wire logic                                    penable,
    input wire logic                                    pwrite,
    input wire logic [preload_observe_pkg::DATA_WIDTH-1:0] prdata,
    input wire logic                                    pready,
    input wire logic                                    pslverr,
    input wire logic [23:0]                             oe_term,
    input wire logic [23:0]                             out_pin,
    input wire logic [23:0]                             out_pin_oe
);
    import preload_observe_pkg::*;
    // cycles since reset release, saturating so it never wraps into clear
    logic [7:0] up_cnt;
    logic [7:0] next_up_cnt;
    always_comb begin
        next_up_cnt = up_cnt;
        if (up_cnt != 8'hff)
            next_up_cnt = up_cnt + 8'h01;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            up_cnt <= 8'h00;
        else
            up_cnt <= next_up_cnt;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready high for more than one cycle");
    AST_ONE_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ERR_RDATA: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_RDATA_HOLD: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data changed outside a read");
    AST_OE_DELAY: assert property ($past(presetn) |-> out_pin_oe == $past(oe_term))
        else $error("pin enable does not follow its term");
    AST_CLEAR_LOW: assert property (up_cnt < CLEAR_CNT_LAST |-> out_pin == 24'h000000)
        else $error("pins not low during power-up clear");
endmodule
bind register_preload_observe_test preload_observe_checker chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oe_term(oe_term), .out_pin(out_pin), .out_pin_oe(out_pin_oe)
);
`default_nettype wire

// [verification/preload_tester.sv]
// model of the external tester driving the mode and preload pins
`timescale 1ns/1ns
`default_nettype none
module preload_tester (
    input  wire logic        pclk,
    output var  logic        preload_enable,
    output var  logic        observe_enable,
    output var  logic        preload_clock,
    output var  logic        flop_choice,
    output var  logic        bank_parity,
    output var  logic [23:0] io_pin_in
);
    initial begin
        preload_enable = 1'b0;
        observe_enable = 1'b0;
        preload_clock = 1'b0;
        flop_choice = 1'b0;
        bank_parity = 1'b0;
        io_pin_in = 24'h000000;
    end
    // enables stand in for the high-voltage levels, held until changed
    task automatic modes(input logic pe, input logic oe);
        @(posedge pclk);
        preload_enable <= pe;
        observe_enable <= oe;
    endtask
    // pins settle a cycle ahead of the strobe; caller never pulses in clear
    task automatic pulse(input logic fc, input logic bp, input logic [23:0] pins);
        @(posedge pclk);
        flop_choice <= fc;
        bank_parity <= bp;
        io_pin_in <= pins;
        @(posedge pclk);
        preload_clock <= 1'b1;
        @(posedge pclk);
        preload_clock <= 1'b0;
        @(posedge pclk);
        // released pins must not keep showing the loaded level
        io_pin_in <= ~pins;
    endtask
endmodule
`default_nettype wire

// [verification/register_preload_observe_test_tb_top.sv]
// self-checking bench for the preload, observe, clear and lock block
`timescale 1ns/1ns
`default_nettype none
module register_preload_observe_test_tb_top;
    import preload_observe_pkg::*;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic            preload_enable, observe_enable, preload_clock;
    logic            flop_choice, bank_parity, er;
    logic [23:0]     io_pin_in, comb_term, oe_term, out_pin, out_pin_oe;
    logic [23:0]     exp_first, exp_second, pins;
    macro_terms_type terms;
    int              error_cnt, n_checks, cycles;
    register_preload_observe_test uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .preload_enable(preload_enable),
        .observe_enable(observe_enable), .preload_clock(preload_clock),
        .flop_choice(flop_choice), .bank_parity(bank_parity),
        .io_pin_in(io_pin_in), .terms(terms), .comb_term(comb_term),
        .oe_term(oe_term), .out_pin(out_pin), .out_pin_oe(out_pin_oe)
    );
    preload_tester tester (
        .pclk(pclk), .preload_enable(preload_enable),
        .observe_enable(observe_enable), .preload_clock(preload_clock),
        .flop_choice(flop_choice), .bank_parity(bank_parity),
        .io_pin_in(io_pin_in)
    );
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;
    ////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_word(input string name, input logic [31:0] exp,
                            input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer; the wait is bounded, not assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
            chk_word("pready", 32'h1, 32'h0);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a,
                          input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_word(name, exp, rd);
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        terms = '0;
        comb_term = 24'h3c3c3c;
        oe_term = 24'h000000;
        {error_cnt, n_checks, cycles} = '0;
        {exp_first, exp_second, pins} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("status clearing", STATUS_ADDR, 32'h00000008);
        repeat (130) @(posedge pclk);
        rd_chk("status idle", STATUS_ADDR, 32'h0);
        rd_chk("first cleared", FIRST_STATE_ADDR, 32'h0);
        rd_chk("second cleared", SECOND_STATE_ADDR, 32'h0);
        apb(1'b1, POLARITY_ADDR, 32'h00ffffff);
        tester.modes(1'b1, 1'b0);
        repeat (2) @(posedge pclk);
        rd_chk("status preload", STATUS_ADDR, 32'h00000001);
        for (int c = 0; c < 4; c++) begin
            pins = pins + 24'h9c36e1;
            tester.pulse(c[1], c[0], pins);
            for (int k = 0; k < 12; k++)
                if (c[1])
                    exp_second[2*k+c[0]] = pins[2*k+1];
                else
                    exp_first[2*k+c[0]] = pins[2*k+1];
            rd_chk("first", FIRST_STATE_ADDR, {8'h00, exp_first});
            rd_chk("second", SECOND_STATE_ADDR, {8'h00, exp_second});
        end
        tester.modes(1'b0, 1'b0);
        repeat (2) @(posedge pclk);
        rd_chk("status released", STATUS_ADDR, 32'h0);
        apb(1'b1, COMB_CONFIG_ADDR, 32'h0000000f);
        rd_chk("buried mask", BURIED_MASK_ADDR, 32'h0000000f);
        oe_term <= 24'hffffff;
        tester.modes(1'b0, 1'b1);
        repeat (3) @(posedge pclk);
        chk_word("observed", {8'h00, exp_second}, {8'h00, out_pin});
        chk_word("pin enable", 32'h00ffffff, {8'h00, out_pin_oe});
        rd_chk("status observe", STATUS_ADDR, 32'h00000002);
        tester.modes(1'b0, 1'b0);
        repeat (3) @(posedge pclk);
        pins = ((exp_first & ~24'h00000f) | (comb_term & 24'h00000f));
        chk_word("normal", {8'h00, ~pins}, {8'h00, out_pin});
        terms.first_d <= 24'hffffff;
        terms.second_d <= 24'hffffff;
        terms.second_rst <= 24'h000001;
        terms.first_rst <= 24'h000002;
        @(posedge pclk);
        terms.first_clk <= 24'h000020;
        terms.second_clk <= 24'h000002;
        exp_first[5] = 1'b1;
        exp_first[1] = 1'b0;
        exp_second[0] = 1'b0;
        exp_second[1] = 1'b1;
        repeat (2) @(posedge pclk);
        terms <= '0;
        rd_chk("own clock", FIRST_STATE_ADDR, {8'h00, exp_first});
        rd_chk("own reset", SECOND_STATE_ADDR, {8'h00, exp_second});
        apb(1'b1, PATTERN_ADDR_ADDR, 32'h00000005);
        apb(1'b1, PATTERN_DATA_ADDR, 32'h1234abcd);
        rd_chk("pattern", PATTERN_DATA_ADDR, 32'h1234abcd);
        apb(1'b1, LOCK_ADDR, 32'h00000001);
        rd_chk("locked pattern", PATTERN_DATA_ADDR, PROGRAMMED_WORD);
        tester.modes(1'b1, 1'b1);
        tester.pulse(1'b0, 1'b0, 24'hffffff);
        rd_chk("status locked", STATUS_ADDR, 32'h00000004);
        rd_chk("locked first", FIRST_STATE_ADDR, {8'h00, exp_first});
        tester.modes(1'b0, 1'b0);
        apb(1'b0, 8'h40, 32'h0);
        chk_word("unmapped error", 32'h1, {31'h0, er});
        chk_word("unmapped data", 32'h0, rd);
        end_of_test();
    end
endmodule
`default_nettype wire
